// ==== isg_regs.vh ====
`ifndef ISG_REGS_VH
`define ISG_REGS_VH

// ---------------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------------
`define ISG_OFS_OP_COND 8'h00
`define ISG_OFS_OP_RISE 8'h04
`define ISG_OFS_OP_FALL 8'h08
`define ISG_OFS_OP_EVT 8'h0C
`define ISG_OFS_OP_EN 8'h10
`define ISG_OFS_AB_COND 8'h14
`define ISG_OFS_AB_RISE 8'h18
`define ISG_OFS_AB_FALL 8'h1C
`define ISG_OFS_AB_EVT 8'h20
`define ISG_OFS_AB_EN 8'h24

// ---------------------------------------------------------------------------
// Field layout and reset values
// ---------------------------------------------------------------------------
`define ISG_REG_W 16
`define ISG_OP_MASK 16'h0FFF
`define ISG_AB_MASK 16'h03FB
`define ISG_RST_VAL 16'h0000
`define ISG_STB_OP_BIT 7
`define ISG_STB_AB_BIT 3

// Operation condition bit positions.
`define ISG_OP_CV 0
`define ISG_OP_CC 1
`define ISG_OP_CR 2
`define ISG_OP_CP 3
`define ISG_OP_OFF 4
`define ISG_OP_SHORT 5
`define ISG_OP_ACQ_WAIT 6
`define ISG_OP_SEQ_WAIT 7
`define ISG_OP_LOG_WAIT 8
`define ISG_OP_ACQ_ACT 9
`define ISG_OP_SEQ_ACT 10
`define ISG_OP_LOG_ACT 11

// Abnormal condition bit positions.
`define ISG_AB_HV 0
`define ISG_AB_HC 1
`define ISG_AB_PWR 3
`define ISG_AB_THERM 4
`define ISG_AB_NHV 5
`define ISG_AB_CLAMP 6
`define ISG_AB_UNREG 7
`define ISG_AB_BLOCK 8
`define ISG_AB_LV 9

// ---------------------------------------------------------------------------
// AXI4-Lite responses
// ---------------------------------------------------------------------------
`define ISG_RESP_OKAY 2'h0
`define ISG_RESP_SLVERR 2'h2

`endif

// ==== isg_group.v ====
`timescale 1ns/1ps
`include "isg_regs.vh"

module isg_group #(
  parameter W = 16,
  parameter [15:0] MASK = 16'hFFFF
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] cond_in,
  input wire [W-1:0] rise_filter,
  input wire [W-1:0] fall_filter,
  input wire [W-1:0] enable,
  input wire evt_clear,
  output wire [W-1:0] cond,
  output reg [W-1:0] event_r,
  output wire summary
);
  reg [W-1:0] cond_prev_r;
  wire [W-1:0] hit;
  genvar i;

  assign cond = cond_in & MASK[W-1:0];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cond_prev_r <= {W{1'b0}};
    end else begin
      cond_prev_r <= cond;
    end
  end

  // ---------------------------------------------------------------------------
  // Per-bit transition filter and sticky event latch
  // ---------------------------------------------------------------------------
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      assign hit[i] = (rise_filter[i] & cond[i] & ~cond_prev_r[i]) |
                      (fall_filter[i] & ~cond[i] & cond_prev_r[i]);
      // A new transition in the clearing cycle wins over the read clear.
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          event_r[i] <= 1'b0;
        end else if (hit[i]) begin
          event_r[i] <= 1'b1;
        end else if (evt_clear) begin
          event_r[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign summary = |(event_r & enable);
endmodule // isg_group

// ==== isg_top.v ====
`timescale 1ns/1ps
`include "isg_regs.vh"

// Functional notes
// - Condition registers mirror live inputs every cycle, unlatched.
// - Rise-filter bit passes low-to-high condition changes into the event bit.
// - Fall-filter bit passes high-to-low condition changes into the event bit.
// - Both filters pass every edge; neither filter passes none.
// - Event bit latches on first qualified edge and stays set until its event register is read.
// - Event registers are read-only; writes do not alter them.
// - Enable registers are read/write and gate events into the summary.
// - Registers are written and read as binary-weighted integers.
// - Enabled operation events OR together onto status byte bit 7.
// - Enabled abnormal events OR together onto status byte bit 3.
// - Operation bits 0-3 flag voltage, current, resistance, power regulation.
// - Operation bit 4 means input off; bit 5 terminals shorted.
// - Operation bits 6-8 flag acquire, sequence, logger awaiting trigger.
// - Operation bits 9-11 flag acquire, sequence, logger initiated.
// - Abnormal bits 0 and 1 flag over-voltage and over-current disable.
// - Abnormal bit 3 flags positive power limit.
// - Abnormal bit 4 flags thermal trip; bit 5 negative over-voltage.
// - Abnormal bit 6 flags the mode-dependent opposite clamp limit.
// - Abnormal bit 7 flags lost regulation; bit 8 external inhibit.
// - Abnormal bit 9 flags under-voltage disable.

module isg_top (
  input wire clk,
  input wire rst_n,
  input wire const_voltage_flag,
  input wire const_current_flag,
  input wire const_resistance_flag,
  input wire const_power_flag,
  input wire input_off_flag,
  input wire terminals_bridged_flag,
  input wire acquire_trigger_wait,
  input wire sequence_trigger_wait,
  input wire logger_trigger_wait,
  input wire acquire_active,
  input wire sequence_active,
  input wire logger_active,
  input wire high_voltage_trip,
  input wire high_current_trip,
  input wire power_limit_flag,
  input wire thermal_trip,
  input wire negative_high_voltage_trip,
  input wire opposite_clamp_flag,
  input wire regulation_lost_flag,
  input wire external_block_flag,
  input wire low_voltage_trip,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg operation_summary,
  output reg abnormal_summary
);
  localparam W = `ISG_REG_W;

  // ---------------------------------------------------------------------------
  // Reset synchroniser
  // ---------------------------------------------------------------------------
  // Reset is taken at once and released only after two clock edges, so every register behind the
  // synchroniser leaves reset in the same cycle.
  reg rst_meta_r;
  reg rst_sync_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Condition assembly
  // ---------------------------------------------------------------------------
  // Condition inputs are wired straight through, and unused positions stay at zero.
  reg [W-1:0] op_raw;
  reg [W-1:0] ab_raw;
  always @* begin
    op_raw = {W{1'b0}};
    op_raw[`ISG_OP_CV] = const_voltage_flag;
    op_raw[`ISG_OP_CC] = const_current_flag;
    op_raw[`ISG_OP_CR] = const_resistance_flag;
    op_raw[`ISG_OP_CP] = const_power_flag;
    op_raw[`ISG_OP_OFF] = input_off_flag;
    op_raw[`ISG_OP_SHORT] = terminals_bridged_flag;
    op_raw[`ISG_OP_ACQ_WAIT] = acquire_trigger_wait;
    op_raw[`ISG_OP_SEQ_WAIT] = sequence_trigger_wait;
    op_raw[`ISG_OP_LOG_WAIT] = logger_trigger_wait;
    op_raw[`ISG_OP_ACQ_ACT] = acquire_active;
    op_raw[`ISG_OP_SEQ_ACT] = sequence_active;
    op_raw[`ISG_OP_LOG_ACT] = logger_active;
    ab_raw = {W{1'b0}};
    ab_raw[`ISG_AB_HV] = high_voltage_trip;
    ab_raw[`ISG_AB_HC] = high_current_trip;
    ab_raw[`ISG_AB_PWR] = power_limit_flag;
    ab_raw[`ISG_AB_THERM] = thermal_trip;
    ab_raw[`ISG_AB_NHV] = negative_high_voltage_trip;
    ab_raw[`ISG_AB_CLAMP] = opposite_clamp_flag;
    ab_raw[`ISG_AB_UNREG] = regulation_lost_flag;
    ab_raw[`ISG_AB_BLOCK] = external_block_flag;
    ab_raw[`ISG_AB_LV] = low_voltage_trip;
  end

  // ---------------------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------------------
  // Filters and enables reset to zero, so no event is latched and no summary is raised until
  // software programs them.
  reg [W-1:0] operation_rise_filter_r;
  reg [W-1:0] operation_fall_filter_r;
  reg [W-1:0] operation_enable_r;
  reg [W-1:0] abnormal_rise_filter_r;
  reg [W-1:0] abnormal_fall_filter_r;
  reg [W-1:0] abnormal_enable_r;
  wire [W-1:0] operation_condition;
  wire [W-1:0] abnormal_condition;
  wire [W-1:0] operation_event;
  wire [W-1:0] abnormal_event;
  wire op_sum;
  wire ab_sum;
  reg op_evt_clr;
  reg ab_evt_clr;

  isg_group #(.W(W), .MASK(`ISG_OP_MASK)) u_op (
    .clk(clk),
    .rst_n(rst_sync_r),
    .cond_in(op_raw),
    .rise_filter(operation_rise_filter_r),
    .fall_filter(operation_fall_filter_r),
    .enable(operation_enable_r),
    .evt_clear(op_evt_clr),
    .cond(operation_condition),
    .event_r(operation_event),
    .summary(op_sum)
  );

  isg_group #(.W(W), .MASK(`ISG_AB_MASK)) u_ab (
    .clk(clk),
    .rst_n(rst_sync_r),
    .cond_in(ab_raw),
    .rise_filter(abnormal_rise_filter_r),
    .fall_filter(abnormal_fall_filter_r),
    .enable(abnormal_enable_r),
    .evt_clear(ab_evt_clr),
    .cond(abnormal_condition),
    .event_r(abnormal_event),
    .summary(ab_sum)
  );

  // ---------------------------------------------------------------------------
  // Status byte summaries
  // ---------------------------------------------------------------------------
  // Both summaries are registered, so each follows its event register by one cycle.
  always @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      operation_summary <= 1'b0;
      abnormal_summary <= 1'b0;
    end else begin
      operation_summary <= op_sum;
      abnormal_summary <= ab_sum;
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------------------
  reg aw_held_r;
  reg w_held_r;
  reg [7:0] aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  wire aw_take;
  wire w_take;
  wire wr_go;
  reg [7:0] wr_addr;
  reg [31:0] wr_data;
  reg [3:0] wr_strb;
  reg [W-1:0] wr_val_lo;
  reg wr_ok;

  // An address or data beat that arrives alone is held until its partner arrives, and no new
  // beat is taken while a response waits, so only one write is under way at a time.
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_go = (aw_held_r || aw_take) && (w_held_r || w_take);

  always @* begin
    wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
    wr_data = w_held_r ? w_data_r : s_axi_wdata;
    wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
    wr_val_lo = wr_data[W-1:0];
    case (wr_addr)
      `ISG_OFS_OP_COND, `ISG_OFS_OP_RISE, `ISG_OFS_OP_FALL, `ISG_OFS_OP_EVT,
      `ISG_OFS_OP_EN, `ISG_OFS_AB_COND, `ISG_OFS_AB_RISE, `ISG_OFS_AB_FALL,
      `ISG_OFS_AB_EVT, `ISG_OFS_AB_EN: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Byte-lane merge of a 16-bit register with strobes.
  function [15:0] merge;
    input [15:0] old;
    input [15:0] val;
    input [1:0] strb;
    input [15:0] mask;
    begin
      merge[7:0] = strb[0] ? val[7:0] : old[7:0];
      merge[15:8] = strb[1] ? val[15:8] : old[15:8];
      merge = merge & mask;
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Write response and register update
  // ---------------------------------------------------------------------------
  always @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ISG_RESP_OKAY;
      operation_rise_filter_r <= `ISG_RST_VAL;
      operation_fall_filter_r <= `ISG_RST_VAL;
      operation_enable_r <= `ISG_RST_VAL;
      abnormal_rise_filter_r <= `ISG_RST_VAL;
      abnormal_fall_filter_r <= `ISG_RST_VAL;
      abnormal_enable_r <= `ISG_RST_VAL;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `ISG_RESP_OKAY : `ISG_RESP_SLVERR;
        // Condition and event offsets accept the write and change nothing.
        case (wr_addr)
          `ISG_OFS_OP_RISE: operation_rise_filter_r <= merge(operation_rise_filter_r,
            wr_val_lo, wr_strb[1:0], `ISG_OP_MASK);
          `ISG_OFS_OP_FALL: operation_fall_filter_r <= merge(operation_fall_filter_r,
            wr_val_lo, wr_strb[1:0], `ISG_OP_MASK);
          `ISG_OFS_OP_EN: operation_enable_r <= merge(operation_enable_r,
            wr_val_lo, wr_strb[1:0], `ISG_OP_MASK);
          `ISG_OFS_AB_RISE: abnormal_rise_filter_r <= merge(abnormal_rise_filter_r,
            wr_val_lo, wr_strb[1:0], `ISG_AB_MASK);
          `ISG_OFS_AB_FALL: abnormal_fall_filter_r <= merge(abnormal_fall_filter_r,
            wr_val_lo, wr_strb[1:0], `ISG_AB_MASK);
          `ISG_OFS_AB_EN: abnormal_enable_r <= merge(abnormal_enable_r,
            wr_val_lo, wr_strb[1:0], `ISG_AB_MASK);
          default: ;
        endcase
      end else begin
        if (aw_take) begin
          aw_held_r <= 1'b1;
          aw_addr_r <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held_r <= 1'b1;
          w_data_r <= s_axi_wdata;
          w_strb_r <= s_axi_wstrb;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------------------
  wire ar_take;
  reg [W-1:0] rd_val;
  reg rd_ok;

  // An event read clears its register at the accepting edge while the read data keeps the bits
  // seen before the clear; a transition in that same cycle sets its bit again.
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  always @* begin
    rd_ok = 1'b1;
    op_evt_clr = 1'b0;
    ab_evt_clr = 1'b0;
    case (s_axi_araddr)
      `ISG_OFS_OP_COND: rd_val = operation_condition;
      `ISG_OFS_OP_RISE: rd_val = operation_rise_filter_r;
      `ISG_OFS_OP_FALL: rd_val = operation_fall_filter_r;
      `ISG_OFS_OP_EVT: begin
        rd_val = operation_event;
        op_evt_clr = ar_take;
      end
      `ISG_OFS_OP_EN: rd_val = operation_enable_r;
      `ISG_OFS_AB_COND: rd_val = abnormal_condition;
      `ISG_OFS_AB_RISE: rd_val = abnormal_rise_filter_r;
      `ISG_OFS_AB_FALL: rd_val = abnormal_fall_filter_r;
      `ISG_OFS_AB_EVT: begin
        rd_val = abnormal_event;
        ab_evt_clr = ar_take;
      end
      `ISG_OFS_AB_EN: rd_val = abnormal_enable_r;
      default: begin
        rd_val = {W{1'b0}};
        rd_ok = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Read response register
  // ---------------------------------------------------------------------------
  always @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ISG_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_val};
      s_axi_rresp <= rd_ok ? `ISG_RESP_OKAY : `ISG_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // isg_top

// ==== isg_bus_chk.sv ====
`timescale 1ns/1ps
`include "isg_regs.vh"

module isg_bus_chk (
  input wire clk,
  input wire rst_n,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  // ---------------------------------------------------------------------------
  // Bus handshake properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer: assert property (s_wr_taken |=> s_axi_bvalid)
    else $error("write response missing");
  a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read response missing");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == `ISG_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
endmodule // isg_bus_chk

bind isg_top isg_bus_chk isg_bus_chk_i (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ==== isg_stb_model.sv ====
`timescale 1ns/1ps
`include "isg_regs.vh"

// ---------------------------------------------------------------------------
// Status byte consumer: places the two summaries at their byte positions
// ---------------------------------------------------------------------------
module isg_stb_model (
  input wire operation_summary,
  input wire abnormal_summary,
  output wire [7:0] status_byte
);
  assign status_byte = {operation_summary, 3'h0, abnormal_summary, 3'h0};
endmodule // isg_stb_model

// ==== isg_tb.sv ====
`timescale 1ns/1ps
`include "isg_regs.vh"

module tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [15:0] op_v = 16'h0000, ab_v = 16'h0000;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, op_sum, ab_sum;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] stb;
  integer num_errors = 0, cmp_count = 0, cyc = 0, i;
  reg [31:0] d;
  reg [1:0] r;
  reg [7:0] a;
  reg [3:0] strb = 4'hF;

  isg_top isg_top_i (.clk(clk), .rst_n(rst_n), .const_voltage_flag(op_v[0]),
    .const_current_flag(op_v[1]), .const_resistance_flag(op_v[2]), .const_power_flag(op_v[3]),
    .input_off_flag(op_v[4]), .terminals_bridged_flag(op_v[5]), .acquire_trigger_wait(op_v[6]),
    .sequence_trigger_wait(op_v[7]), .logger_trigger_wait(op_v[8]), .acquire_active(op_v[9]),
    .sequence_active(op_v[10]), .logger_active(op_v[11]), .high_voltage_trip(ab_v[0]),
    .high_current_trip(ab_v[1]), .power_limit_flag(ab_v[3]), .thermal_trip(ab_v[4]),
    .negative_high_voltage_trip(ab_v[5]), .opposite_clamp_flag(ab_v[6]),
    .regulation_lost_flag(ab_v[7]), .external_block_flag(ab_v[8]), .low_voltage_trip(ab_v[9]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .operation_summary(op_sum),
    .abnormal_summary(ab_sum));
  isg_stb_model isg_stb_model_i (.operation_summary(op_sum), .abnormal_summary(ab_sum),
    .status_byte(stb));

  // ---------------------------------------------------------------------------
  // Clock, timeout and bus tasks
  // ---------------------------------------------------------------------------
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      complete_run;
    end
  end

  task complete_run;
    begin
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // Each channel is released at the edge where its ready is seen high; the response ready is
  // raised only once valid appears, so the slave must hold its answer for a cycle.
  task wr(input [7:0] ad, input [31:0] dv);
    reg done;
    begin
      @(posedge clk);
      awaddr <= ad;
      wdata <= dv;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      done = 1'b0;
      while (!done) begin
        @(posedge clk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bvalid && bready) begin
          r = bresp;
          bready <= 1'b0;
          done = 1'b1;
        end else if (bvalid) begin
          bready <= 1'b1;
        end
      end
    end
  endtask

  task rd(input [7:0] ad);
    reg done;
    begin
      @(posedge clk);
      araddr <= ad;
      arvalid <= 1'b1;
      done = 1'b0;
      while (!done) begin
        @(posedge clk);
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid && rready) begin
          d = rdata;
          r = rresp;
          rready <= 1'b0;
          done = 1'b1;
        end else if (rvalid) begin
          rready <= 1'b1;
        end
      end
    end
  endtask

  task set_cond(input [15:0] ov, input [15:0] av);
    begin
      @(posedge clk);
      op_v <= ov;
      ab_v <= av;
      repeat (3) @(posedge clk);
    end
  endtask

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    for (i = 0; i < 10; i = i + 1) begin
      rd(i * 4);
      chk(d, 32'h0);
    end
    rd(8'h28);
    chk(r, `ISG_RESP_SLVERR);
    chk(d, 32'h0);
    wr(8'h28, 32'hFFFF);
    chk(r, `ISG_RESP_SLVERR);
    $display("test reset and map done");
    for (i = 0; i < 16; i = i + 1) begin
      set_cond(16'h1 << i, 16'h1 << i);
      rd(`ISG_OFS_OP_COND);
      chk(d, (32'h1 << i) & `ISG_OP_MASK);
      rd(`ISG_OFS_AB_COND);
      chk(d, (32'h1 << i) & `ISG_AB_MASK);
    end
    set_cond(16'h0, 16'h0);
    rd(`ISG_OFS_OP_EVT);
    chk(d, 32'h0);
    $display("test condition mirror done");
    for (i = 0; i < 6; i = i + 1) begin
      a = (i < 3) ? ((i == 2) ? 8'h10 : 8'h04 * (i + 1)) : ((i == 5) ? 8'h24 : 8'h04 * (i + 3));
      wr(a, 32'hFFFFFFFF);
      rd(a);
      chk(d, (i < 3) ? `ISG_OP_MASK : `ISG_AB_MASK);
      wr(a, 32'd20);
      rd(a);
      chk(d, 32'd20 & ((i < 3) ? `ISG_OP_MASK : `ISG_AB_MASK));
      wr(a, 32'h0);
    end
    strb <= 4'h2;
    wr(`ISG_OFS_OP_EN, 32'h0FFF);
    strb <= 4'hF;
    rd(`ISG_OFS_OP_EN);
    chk(d, 32'h0F00);
    wr(`ISG_OFS_OP_EN, 32'h0);
    $display("test read write done");
    wr(`ISG_OFS_OP_RISE, 32'h5);
    wr(`ISG_OFS_OP_FALL, 32'h6);
    set_cond(16'h000F, 16'h0);
    rd(`ISG_OFS_OP_EVT);
    chk(d, 32'h5);
    rd(`ISG_OFS_OP_EVT);
    chk(d, 32'h0);
    wr(`ISG_OFS_OP_EVT, 32'hFFFF);
    chk(r, `ISG_RESP_OKAY);
    rd(`ISG_OFS_OP_EVT);
    chk(d, 32'h0);
    set_cond(16'h0, 16'h0);
    rd(`ISG_OFS_OP_EVT);
    chk(d, 32'h6);
    set_cond(16'h4, 16'h0);
    set_cond(16'h0, 16'h0);
    set_cond(16'h4, 16'h0);
    chk(stb, 8'h00);
    rd(`ISG_OFS_OP_EVT);
    chk(d, 32'h4);
    $display("test edge filters done");
    wr(`ISG_OFS_OP_EN, 32'h4);
    set_cond(16'h0, 16'h0);
    chk(stb, 8'h80);
    rd(`ISG_OFS_OP_EVT);
    chk(d, 32'h4);
    repeat (3) @(posedge clk);
    chk(stb, 8'h00);
    wr(`ISG_OFS_AB_RISE, 32'h200);
    wr(`ISG_OFS_AB_EN, 32'h200);
    set_cond(16'h0, 16'h0200);
    chk(stb, 8'h08);
    wr(`ISG_OFS_AB_EN, 32'h0);
    repeat (3) @(posedge clk);
    chk(stb, 8'h00);
    $display("test summaries done");
    complete_run;
  end
endmodule // tb
